// ===== rtl/evm_pkg.sv
package evm_pkg;

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned XTAL_HZ     = 32_768;
    localparam logic [26:0] PH_MOD      = 27'(CLK_HZ);
    localparam logic [26:0] PH_STEP     = 27'(XTAL_HZ);

    // filter times in microseconds, rounded up to crystal ticks
    localparam longint      FILT1_US    = 3_900;
    localparam longint      FILT2_US    = 15_200;
    localparam longint      FILT3_US    = 31_250;
    localparam logic [10:0] FILT1_TICKS = 11'((FILT1_US * XTAL_HZ + 999_999) / 1_000_000);
    localparam logic [10:0] FILT2_TICKS = 11'((FILT2_US * XTAL_HZ + 999_999) / 1_000_000);
    localparam logic [10:0] FILT3_TICKS = 11'((FILT3_US * XTAL_HZ + 999_999) / 1_000_000);

    // sampling periods in milliseconds, as crystal ticks
    localparam longint      SMPQ_MS     = 4_000;
    localparam longint      SMP1_MS     = 1_000;
    localparam longint      SMP2_MS     = 500;
    localparam logic [17:0] SMPQ_TICKS  = 18'(SMPQ_MS * XTAL_HZ / 1_000);
    localparam logic [17:0] SMP1_TICKS  = 18'(SMP1_MS * XTAL_HZ / 1_000);
    localparam logic [17:0] SMP2_TICKS  = 18'(SMP2_MS * XTAL_HZ / 1_000);
    localparam logic [17:0] SETTLE_TICKS = 18'h0_0002;

    // ----------------------------------------------------------------
    // register map: index, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [5:0]  IDX_CTRL    = 6'h00;
    localparam logic [5:0]  IDX_STAT    = 6'h01;
    localparam logic [5:0]  IDX_STAMP0  = 6'h14;
    localparam logic [5:0]  IDX_STAMP5  = 6'h19;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam int          C_EN = 0, C_BATEN = 1, C_PU = 2, C_FILT = 3, C_SMP = 5;
    localparam int          C_STAMP = 7, C_FRZ = 8, C_LP = 9, C_FO = 12;
    localparam int          S_EVT = 0, S_PLF = 1, S_BATT = 2, S_SEAL = 3;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [1:0]  SMP_CONT    = 2'h0;

    typedef enum logic [2:0] {
        PWR_SEAL = 3'b001,
        PWR_MAIN = 3'b010,
        PWR_BATT = 3'b100
    } evm_pwr_e;

    typedef struct packed {
        logic main_present;
        logic below_bat_hys;
        logic below_trip;
        logic above_bat_hys;
        logic above_trip_hys;
    } evm_cmp_s;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } evm_time_s;

endpackage

// ===== rtl/evm_top.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
// Behaviour
// - high on tamper input means event
// - enable bit cleared gates input off
// - control bit keeps detection in battery
// - detect output low until flag or enable bit cleared
// - valid high sets event flag
// - detect output and optional time stamp
// - optional freeze of clock registers
// - software switches input pull-up
// - input stable for selected filter time
// - continuous or 1/4, 1, 2 Hz sampling
// - battery needs both compares, either recovers
// - battery mode shuts serial bus off
// - other pins stay active in battery
// - flag total power loss after restart
// - low-power bit ignores trip compare
// - no battery draw before main power
// - select alarm interrupt or clock out
// - sampling pulses input sensing on/off
// - stamp readable at indices 14h-19h
module evm_top
    import evm_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             tamper_input_pin,
    input  wire evm_pkg::evm_cmp_s supply_compare,
    input  wire evm_pkg::evm_time_s time_now,
    input  wire logic             alarm_irq,
    output logic                  tamper_detect_output_oe,
    output logic                  tamper_pullup_en,
    output logic                  tamper_sense_en,
    output logic                  rtc_freeze,
    output logic                  serial_bus_en,
    output logic                  battery_mode,
    output logic                  battery_draw_en,
    output logic                  alarm_or_clock_out_pin_oe
);
    import evm_pkg::*;

    // ----------------------------------------------------------------
    // crystal tick from a phase accumulator
    // ----------------------------------------------------------------
    logic [26:0] phase, next_phase;
    logic        xtal_tick, next_xtal_tick;

    // 32.768 kHz enable pulse, one aclk wide
    always_comb begin
        logic [26:0] sum;
        sum            = phase + PH_STEP;
        next_phase     = sum;
        next_xtal_tick = 1'b0;
        if (sum >= PH_MOD) begin
            next_phase     = sum - PH_MOD;
            next_xtal_tick = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase     <= 27'h000_0000;
            xtal_tick <= 1'b0;
        end else begin
            phase     <= next_phase;
            xtal_tick <= next_xtal_tick;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic     pin_s1, pin_s2;
    evm_cmp_s cmp_s1, cmp_s2;

    // two flops each; only the second stage is used
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            cmp_s1 <= '0;
            cmp_s2 <= '0;
        end else begin
            pin_s1 <= tamper_input_pin;
            pin_s2 <= pin_s1;
            cmp_s1 <= supply_compare;
            cmp_s2 <= cmp_s1;
        end
    end

    // ----------------------------------------------------------------
    // supply mode state machine
    // ----------------------------------------------------------------
    evm_pwr_e pwr, next_pwr;
    logic [31:0] ctrl, next_ctrl;

    always_comb begin
        next_pwr = pwr;
        unique case (pwr)
            PWR_SEAL: begin
                if (cmp_s2.main_present) begin
                    next_pwr = PWR_MAIN;
                end
            end
            PWR_MAIN: begin
                if (ctrl[C_LP] && cmp_s2.below_bat_hys) begin
                    next_pwr = PWR_BATT;
                end else if (!ctrl[C_LP] && cmp_s2.below_bat_hys && cmp_s2.below_trip) begin
                    next_pwr = PWR_BATT;
                end
            end
            PWR_BATT: begin
                if (cmp_s2.above_bat_hys || (!ctrl[C_LP] && cmp_s2.above_trip_hys)) begin
                    next_pwr = PWR_MAIN;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr <= PWR_SEAL;
        end else begin
            pwr <= next_pwr;
        end
    end

    // ----------------------------------------------------------------
    // sampling window and glitch filter
    // ----------------------------------------------------------------
    logic [17:0] smp_cnt, next_smp_cnt, smp_period;
    logic [10:0] filt_cnt, next_filt_cnt, filt_ticks;
    logic [14:0] fo_cnt, next_fo_cnt;
    logic        armed, sense_on, gated_in, valid_in;

    // selections, arming and the debounced event
    always_comb begin
        unique case (ctrl[C_FILT +: 2])
            2'h0: filt_ticks = 11'h000;
            2'h1: filt_ticks = FILT1_TICKS;
            2'h2: filt_ticks = FILT2_TICKS;
            2'h3: filt_ticks = FILT3_TICKS;
        endcase
        unique case (ctrl[C_SMP +: 2])
            2'h0: smp_period = 18'h0_0000;
            2'h1: smp_period = SMPQ_TICKS;
            2'h2: smp_period = SMP1_TICKS;
            2'h3: smp_period = SMP2_TICKS;
        endcase
        armed    = ctrl[C_EN] && (pwr != PWR_BATT || ctrl[C_BATEN]);
        sense_on = (ctrl[C_SMP +: 2] == SMP_CONT)
                   || (smp_cnt < {7'h00, filt_ticks} + SETTLE_TICKS);
        gated_in = pin_s2 && armed && sense_on;
        valid_in = gated_in && (filt_cnt >= filt_ticks);
        next_smp_cnt = 18'h0_0000;
        if (ctrl[C_SMP +: 2] != SMP_CONT) begin
            next_smp_cnt = smp_cnt;
            if (xtal_tick) begin
                next_smp_cnt = (smp_cnt >= smp_period - 18'h0_0001) ? 18'h0_0000
                                                                    : smp_cnt + 18'h0_0001;
            end
        end
        next_filt_cnt = 11'h000;
        if (gated_in) begin
            next_filt_cnt = filt_cnt;
            if (xtal_tick && filt_cnt < filt_ticks) begin
                next_filt_cnt = filt_cnt + 11'h001;
            end
        end
        next_fo_cnt = xtal_tick ? fo_cnt + 15'h0001 : fo_cnt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smp_cnt  <= 18'h0_0000;
            filt_cnt <= 11'h000;
            fo_cnt   <= 15'h0000;
        end else begin
            smp_cnt  <= next_smp_cnt;
            filt_cnt <= next_filt_cnt;
            fo_cnt   <= next_fo_cnt;
        end
    end

    // ----------------------------------------------------------------
    // register file, flags, time stamp and AXI4-Lite slave
    // ----------------------------------------------------------------
    logic        evt_flag, next_evt_flag, plf_flag, next_plf_flag, evt_set;
    logic [7:0]  stamp [6];
    logic [7:0]  next_stamp [6];
    logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;

    always_comb begin
        logic [5:0] widx, ridx;
        logic       wr_fire, rd_fire;
        widx         = s_axi_awaddr[7:2];
        ridx         = s_axi_araddr[7:2];
        wr_fire      = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
        rd_fire      = s_axi_arready && s_axi_arvalid;
        next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
        next_wready  = next_awready;
        next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        next_bvalid  = s_axi_bvalid && !s_axi_bready;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid && !s_axi_rready;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        next_ctrl    = ctrl;
        next_evt_flag = evt_flag;
        next_plf_flag = plf_flag;
        evt_set      = valid_in && !evt_flag;
        for (int i = 0; i < 6; i++) begin
            next_stamp[i] = stamp[i];
        end
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp  = RESP_OKAY;
            if (widx == IDX_CTRL) begin
                for (int b = 0; b < 4; b++) begin
                    if (s_axi_wstrb[b]) begin
                        next_ctrl[8*b +: 8] = s_axi_wdata[8*b +: 8];
                    end
                end
            end else if (widx == IDX_STAT) begin
                if (s_axi_wstrb[0] && s_axi_wdata[S_EVT]) begin
                    next_evt_flag = 1'b0;
                end
                if (s_axi_wstrb[0] && s_axi_wdata[S_PLF]) begin
                    next_plf_flag = 1'b0;
                end
            end else if (widx < IDX_STAMP0 || widx > IDX_STAMP5) begin
                next_bresp = RESP_SLVERR;
            end
        end
        // a set in the clearing cycle wins; only a fresh event re-stamps
        if (valid_in) begin
            next_evt_flag = 1'b1;
        end
        if (evt_set && ctrl[C_STAMP]) begin
            for (int i = 0; i < 6; i++) begin
                next_stamp[i] = time_now[8*i +: 8];
            end
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (ridx == IDX_CTRL) begin
                next_rdata = ctrl;
            end else if (ridx == IDX_STAT) begin
                next_rdata[S_EVT]  = evt_flag;
                next_rdata[S_PLF]  = plf_flag;
                next_rdata[S_BATT] = (pwr == PWR_BATT);
                next_rdata[S_SEAL] = (pwr == PWR_SEAL);
            end else if (ridx >= IDX_STAMP0 && ridx <= IDX_STAMP5) begin
                next_rdata[7:0] = stamp[3'(ridx - IDX_STAMP0)];
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl          <= CTRL_RST;
            evt_flag      <= 1'b0;
            plf_flag      <= 1'b1;
            stamp         <= '{default: 8'h00};
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            ctrl          <= next_ctrl;
            evt_flag      <= next_evt_flag;
            plf_flag      <= next_plf_flag;
            stamp         <= next_stamp;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // registered pin and supply outputs
    // ----------------------------------------------------------------
    logic next_detect_oe, next_pullup_en, next_sense_en, next_freeze;
    logic next_serial_en, next_draw_en, next_alarm_oe;

    always_comb begin
        logic [3:0] fo;
        fo             = ctrl[C_FO +: 4];
        next_detect_oe = evt_flag && ctrl[C_EN];
        next_pullup_en = ctrl[C_PU] && armed && sense_on;
        next_sense_en  = armed && sense_on;
        next_freeze    = evt_flag && ctrl[C_FRZ];
        next_serial_en = (pwr != PWR_BATT);
        next_draw_en   = (pwr != PWR_SEAL);
        // shared pin stays live in battery mode as well
        if (fo == 4'h0) begin
            next_alarm_oe = alarm_irq;
        end else begin
            next_alarm_oe = !fo_cnt[4'(fo - 4'h1)];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tamper_detect_output_oe   <= 1'b0;
            tamper_pullup_en          <= 1'b0;
            tamper_sense_en           <= 1'b0;
            rtc_freeze                <= 1'b0;
            serial_bus_en             <= 1'b0;
            battery_mode              <= 1'b0;
            battery_draw_en           <= 1'b0;
            alarm_or_clock_out_pin_oe <= 1'b0;
        end else begin
            tamper_detect_output_oe   <= next_detect_oe;
            tamper_pullup_en          <= next_pullup_en;
            tamper_sense_en           <= next_sense_en;
            rtc_freeze                <= next_freeze;
            serial_bus_en             <= next_serial_en;
            battery_mode              <= (pwr == PWR_BATT);
            battery_draw_en           <= next_draw_en;
            alarm_or_clock_out_pin_oe <= next_alarm_oe;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        valid_in |=> evt_flag) else $error("event flag not set");
    a_detect_low: assert property (@(posedge aclk) disable iff (!aresetn)
        evt_flag && ctrl[C_EN] |=> tamper_detect_output_oe) else $error("detect not low");
    a_gate_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl[C_EN] && !evt_flag |=> !evt_flag) else $error("event while disabled");
    a_batt_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr == PWR_BATT && !ctrl[C_BATEN] && !evt_flag |=> !evt_flag)
        else $error("event in battery while barred");
    a_stamp_take: assert property (@(posedge aclk) disable iff (!aresetn)
        evt_set && ctrl[C_STAMP] |=> stamp[0] == $past(time_now.second)
        && stamp[5] == $past(time_now.year)) else $error("stamp not captured");
    a_freeze_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        evt_flag && ctrl[C_FRZ] |=> rtc_freeze) else $error("clock not frozen");
    a_filter_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(gated_in) && filt_ticks != 11'h000 |-> !valid_in) else $error("filter bypassed");
    a_serial_off: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr == PWR_BATT |=> !serial_bus_en) else $error("serial live in battery");
    a_seal_draw: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr == PWR_SEAL |=> !battery_draw_en) else $error("battery drawn before main");
    a_lp_switch: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr == PWR_MAIN && ctrl[C_LP] && cmp_s2.below_bat_hys |=> ##1 battery_mode)
        else $error("low-power switch missed");

endmodule

// ===== verif/evm_switch_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// external tamper switch on the event input pin
// ----------------------------------------------------------------
module evm_switch_model (
    input  wire logic aclk,
    input  wire logic switch_open,
    input  wire logic pullup_en,
    output logic      pin
);
    logic float_q = 1'b0;

    // an open pin with no pull-up floats, so it wanders every cycle
    always_ff @(posedge aclk) begin
        float_q <= ~float_q;
    end

    // closed switch ties the pin low, open switch lets the pull-up lift it
    assign pin = !switch_open ? 1'b0 : (pullup_en ? 1'b1 : float_q);
endmodule

// ===== verif/evm_top_test.sv
`timescale 1ns/100ps
module evm_top_test;
    import evm_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alarm_irq;
    logic        awready, wready, bvalid, arready, rvalid, sw_open, pin;
    logic        oe_det, pu_en, sense_en, freeze, bus_en, bat_mode, draw_en, oe_alm;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [63:0] tm;
    evm_cmp_s    cmp;
    evm_time_s   tnow;
    int          fail_count, n_tests, i, j;

    evm_top evm_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .tamper_input_pin(pin), .supply_compare(cmp),
        .time_now(tnow), .alarm_irq(alarm_irq), .tamper_detect_output_oe(oe_det),
        .tamper_pullup_en(pu_en), .tamper_sense_en(sense_en), .rtc_freeze(freeze),
        .serial_bus_en(bus_en), .battery_mode(bat_mode), .battery_draw_en(draw_en),
        .alarm_or_clock_out_pin_oe(oe_alm));

    evm_switch_model evm_switch_model_i (.aclk(aclk), .switch_open(sw_open),
        .pullup_en(pu_en), .pin(pin));

    // clock at 100 MHz
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bounded wait for a level sampled at the rising edge
    task automatic wait_for(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s !== v && n < lim);
        if (s !== v) begin
            fail_count++;
            $display("ERROR wait expected %h seen %h", v, s);
            end_of_test();
        end
    endtask

    task automatic axi_wr(logic [5:0] idx, logic [31:0] d);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wait_for(awready, 1'b1, 200);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_for(bvalid, 1'b1, 200);
        rsp = bresp;
    endtask

    task automatic rd_chk(logic [5:0] idx, logic [31:0] exp, logic [1:0] rexp);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        wait_for(arready, 1'b1, 200);
        arvalid <= 1'b0;
        wait_for(rvalid, 1'b1, 200);
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, rexp}, {30'h0, rresp});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(22738));
        {aresetn, awvalid, wvalid, arvalid, alarm_irq, sw_open} = '0;
        {awaddr, araddr, wdata, cmp, tnow} = '0;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // restart after total loss: flag set, sealed, no battery draw
        chk("draw_en", 32'h0, draw_en);
        rd_chk(IDX_STAT, 32'h0000_000a, RESP_OKAY);
        rd_chk(6'h3f, 32'h0, RESP_SLVERR);
        axi_wr(6'h3f, 32'hffff_ffff);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        cmp.main_present <= 1'b1;
        wait_for(draw_en, 1'b1, 50);
        axi_wr(IDX_STAT, 32'h0000_0002);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        rd_chk(IDX_STAT, 32'h0, RESP_OKAY);
        // one comparison alone keeps main, both enter battery
        cmp.below_bat_hys <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("bat_mode", 32'h0, bat_mode);
        cmp.below_trip <= 1'b1;
        wait_for(bat_mode, 1'b1, 50);
        chk("bus_en", 32'h0, bus_en);
        cmp <= 5'b10001;
        wait_for(bat_mode, 1'b0, 50);
        chk("bus_en", 32'h1, bus_en);
        // low-power switching ignores the trip comparison
        cmp <= 5'b10000;
        axi_wr(IDX_CTRL, 32'h0000_0200);
        cmp.below_bat_hys <= 1'b1;
        wait_for(bat_mode, 1'b1, 50);
        cmp <= 5'b10010;
        wait_for(bat_mode, 1'b0, 50);
        cmp <= 5'b10000;
        // tamper events with stamp and freeze, random times
        axi_wr(IDX_CTRL, 32'h0000_0185);
        @(posedge aclk);
        chk("pullup", 32'h1, pu_en);
        chk("sense", 32'h1, sense_en);
        for (i = 0; i < 3; i++) begin
            tm = {$urandom(), $urandom()};
            tnow <= tm[47:0];
            repeat ($urandom_range(20, 1)) @(posedge aclk);
            sw_open <= 1'b1;
            wait_for(oe_det, 1'b1, 20);
            chk("freeze", 32'h1, freeze);
            rd_chk(IDX_STAT, 32'h0000_0001, RESP_OKAY);
            for (j = 0; j < 6; j++) begin
                rd_chk(IDX_STAMP0 + 6'(j), {24'h0, tm[8*j +: 8]}, RESP_OKAY);
            end
            sw_open <= 1'b0;
            repeat (4) @(posedge aclk);
            chk("det_held", 32'h1, oe_det);
            axi_wr(IDX_STAT, 32'h0000_0001);
            wait_for(oe_det, 1'b0, 20);
            chk("freeze", 32'h0, freeze);
        end
        // glitch far shorter than the 3.9 ms filter is ignored
        axi_wr(IDX_CTRL, 32'h0000_018d);
        sw_open <= 1'b1;
        repeat ($urandom_range(3000, 500)) @(posedge aclk);
        sw_open <= 1'b0;
        repeat (20) @(posedge aclk);
        rd_chk(IDX_STAT, 32'h0, RESP_OKAY);
        // 2 Hz sampling: sensing and pull-up drop once the short window ends
        axi_wr(IDX_CTRL, 32'h0000_0065);
        wait_for(sense_en, 1'b0, 8000);
        chk("pullup_smp", 32'h0, pu_en);
        sw_open <= 1'b1;
        repeat (30) @(posedge aclk);
        chk("det_smp", 32'h0, oe_det);
        sw_open <= 1'b0;
        // detection switched off
        axi_wr(IDX_CTRL, 32'h0000_0004);
        sw_open <= 1'b1;
        repeat (30) @(posedge aclk);
        rd_chk(IDX_STAT, 32'h0, RESP_OKAY);
        // battery mode without the keep-running bit gates detection
        sw_open <= 1'b0;
        axi_wr(IDX_CTRL, 32'h0000_0085);
        cmp <= 5'b11100;
        wait_for(bat_mode, 1'b1, 50);
        sw_open <= 1'b1;
        repeat (30) @(posedge aclk);
        chk("det_bat", 32'h0, oe_det);
        chk("pullup_bat", 32'h0, pu_en);
        alarm_irq <= 1'b1;
        wait_for(oe_alm, 1'b1, 20);
        alarm_irq <= 1'b0;
        wait_for(oe_alm, 1'b0, 20);
        sw_open <= 1'b0;
        cmp <= 5'b10001;
        wait_for(bat_mode, 1'b0, 50);
        // shared pin: alarm interrupt, then clock output
        alarm_irq <= 1'b1;
        wait_for(oe_alm, 1'b1, 20);
        alarm_irq <= 1'b0;
        wait_for(oe_alm, 1'b0, 20);
        axi_wr(IDX_CTRL, 32'h0000_1000);
        wait_for(oe_alm, 1'b1, 8000);
        wait_for(oe_alm, 1'b0, 8000);
        end_of_test();
    end
endmodule
